// file: mwd_map.vh
// Configuration offsets, field positions and reset values of the
// memory window decode block. Definitions only.
`ifndef MWD_MAP_VH
`define MWD_MAP_VH

// Configuration byte offsets
`define MWD_OFF_MEM_LOW 8'h20
`define MWD_OFF_MEM_HIGH 8'h22
`define MWD_OFF_PF_LOW 8'h24
`define MWD_OFF_PF_HIGH 8'h26
`define MWD_OFF_PF_LOW_UP 8'h28
`define MWD_OFF_PF_HIGH_UP 8'h2c

// Field positions inside the 16-bit window registers
`define MWD_FIELD_MSB 15
`define MWD_FIELD_LSB 4
`define MWD_FLAG_MSB 3
`define MWD_FLAG_LSB 0

// Reset values
`define MWD_RST_MEM 12'h000
`define MWD_RST_PF 12'h000
`define MWD_RST_UP 32'h0000_0000

// Read-only low nibbles
`define MWD_MEM_FLAG 4'h0
`define MWD_WIDE_FLAG 4'h1

// Implied low address bits of base and limit
`define MWD_LOW_ZEROS 20'h00000
`define MWD_LOW_ONES 20'hfffff

`endif

// file: mwd_window.v
// Memory window decode: four 16-bit window registers plus the two
// upper 32-bit prefetchable registers, and the forward decision.
// Assumes a simple configuration port with byte enables from the
// owning header logic; accesses are one aligned dword at a time.
//
// Behaviour
// R1 - Memory base field gives address 31:20; low 20 bits are zero.
// R2 - Memory limit field gives address 31:20; low 20 bits are ones.
// R3 - Memory base and limit bits 3:0 read zero and ignore writes.
// R4 - Forward memory transactions downstream when address lies in window.
// R5 - Prefetch base field gives address 31:20; low 20 bits are zero.
// R6 - Prefetch limit field gives address 31:20; low 20 bits are ones.
// R7 - Prefetch base bits 63:32 come from upper register at 28h.
// R8 - Prefetch limit bits 63:32 come from upper register at 2Ch.
// R9 - Prefetch base and limit bits 3:0 read 1, marking 64-bit support.
// R10 - Windows decide whether a transaction crosses between interfaces.
// R11 - Base above limit disables window; prefetch compares full 64 bits.
`timescale 1ns/10ps
`include "mwd_map.vh"

module mwd_window (
  // Clock and reset
  input wire clock,
  input wire reset_n,
  // Configuration port
  input wire cfg_wr,
  input wire cfg_rd,
  input wire [7:0] cfg_addr,
  input wire [3:0] cfg_be,
  input wire [31:0] cfg_wdata,
  output reg [31:0] cfg_rdata,
  output reg cfg_hit,
  // Transaction address check
  input wire txn_valid,
  input wire [63:0] txn_addr,
  input wire txn_from_upstream,
  output reg fwd_valid,
  output reg fwd_hit,
  output reg fwd_cross
);

  reg [11:0] memory_window_start_field_reg;
  reg [11:0] memory_window_end_field_reg;
  reg [11:0] prefetch_window_start_field_reg;
  reg [11:0] prefetch_window_end_field_reg;
  reg [31:0] pf_low_up_reg;
  reg [31:0] pf_high_up_reg;

  wire [7:0] dw_addr;
  wire sel_mem;
  wire sel_pf;
  wire sel_low_up;
  wire sel_high_up;
  wire [31:0] mem_base;
  wire [31:0] mem_limit;
  wire [63:0] pf_base;
  wire [63:0] pf_limit;
  wire mem_en;
  wire pf_en;
  wire in_mem;
  wire in_pf;
  wire in_any;
  wire [3:0] mem_lane_we;
  wire [3:0] pf_lane_we;
  wire [3:0] low_up_lane_we;
  wire [3:0] high_up_lane_we;

  assign dw_addr = {cfg_addr[7:2], 2'b00};
  assign sel_mem = (dw_addr == `MWD_OFF_MEM_LOW);
  assign sel_pf = (dw_addr == `MWD_OFF_PF_LOW);
  assign sel_low_up = (dw_addr == `MWD_OFF_PF_LOW_UP);
  assign sel_high_up = (dw_addr == `MWD_OFF_PF_HIGH_UP);

  // Window bounds; low bits implied, never stored
  assign mem_base = {memory_window_start_field_reg, `MWD_LOW_ZEROS}; // [R1]
  assign mem_limit = {memory_window_end_field_reg, `MWD_LOW_ONES}; // [R2]
  assign pf_base = {pf_low_up_reg, prefetch_window_start_field_reg,
    `MWD_LOW_ZEROS}; // [R5] [R7]
  assign pf_limit = {pf_high_up_reg, prefetch_window_end_field_reg,
    `MWD_LOW_ONES}; // [R6] [R8]

  // Base above limit disables; reset leaves both windows 1 MB at zero
  assign mem_en = (mem_base <= mem_limit); // [R11]
  assign pf_en = (pf_base <= pf_limit); // [R11]
  assign in_mem = mem_en && (txn_addr[63:32] == 32'h0000_0000) &&
    (txn_addr[31:0] >= mem_base) && (txn_addr[31:0] <= mem_limit); // [R4]
  assign in_pf = pf_en && (txn_addr >= pf_base) &&
    (txn_addr <= pf_limit); // [R4] [R11]
  assign in_any = in_mem || in_pf;

  // Per-lane write enables; lanes of one dword are independent
  assign mem_lane_we = {4{cfg_wr && sel_mem}} & cfg_be;
  assign pf_lane_we = {4{cfg_wr && sel_pf}} & cfg_be;
  assign low_up_lane_we = {4{cfg_wr && sel_low_up}} & cfg_be;
  assign high_up_lane_we = {4{cfg_wr && sel_high_up}} & cfg_be;

  // Memory window fields; low nibbles not stored, so writes drop them
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      memory_window_start_field_reg <= `MWD_RST_MEM;
      memory_window_end_field_reg <= `MWD_RST_MEM;
    end
    else
    begin
      if (mem_lane_we[0])
        memory_window_start_field_reg[3:0] <= cfg_wdata[7:4]; // [R3]
      if (mem_lane_we[1])
        memory_window_start_field_reg[11:4] <= cfg_wdata[15:8];
      if (mem_lane_we[2])
        memory_window_end_field_reg[3:0] <= cfg_wdata[23:20]; // [R3]
      if (mem_lane_we[3])
        memory_window_end_field_reg[11:4] <= cfg_wdata[31:24];
    end
  end

  // Prefetch window fields; wide flag nibbles are constants
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prefetch_window_start_field_reg <= `MWD_RST_PF;
      prefetch_window_end_field_reg <= `MWD_RST_PF;
    end
    else
    begin
      if (pf_lane_we[0])
        prefetch_window_start_field_reg[3:0] <= cfg_wdata[7:4]; // [R9]
      if (pf_lane_we[1])
        prefetch_window_start_field_reg[11:4] <= cfg_wdata[15:8];
      if (pf_lane_we[2])
        prefetch_window_end_field_reg[3:0] <= cfg_wdata[23:20]; // [R9]
      if (pf_lane_we[3])
        prefetch_window_end_field_reg[11:4] <= cfg_wdata[31:24];
    end
  end

  // Upper prefetch base, all 32 bits writable
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      pf_low_up_reg <= `MWD_RST_UP;
    else
    begin
      if (low_up_lane_we[0])
        pf_low_up_reg[7:0] <= cfg_wdata[7:0]; // [R7]
      if (low_up_lane_we[1])
        pf_low_up_reg[15:8] <= cfg_wdata[15:8];
      if (low_up_lane_we[2])
        pf_low_up_reg[23:16] <= cfg_wdata[23:16];
      if (low_up_lane_we[3])
        pf_low_up_reg[31:24] <= cfg_wdata[31:24];
    end
  end

  // Upper prefetch limit, all 32 bits writable
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      pf_high_up_reg <= `MWD_RST_UP;
    else
    begin
      if (high_up_lane_we[0])
        pf_high_up_reg[7:0] <= cfg_wdata[7:0]; // [R8]
      if (high_up_lane_we[1])
        pf_high_up_reg[15:8] <= cfg_wdata[15:8];
      if (high_up_lane_we[2])
        pf_high_up_reg[23:16] <= cfg_wdata[23:16];
      if (high_up_lane_we[3])
        pf_high_up_reg[31:24] <= cfg_wdata[31:24];
    end
  end

  // Read data registered one cycle after the read strobe
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_rdata <= 32'h0000_0000;
      cfg_hit <= 1'b0;
    end
    else
    begin
      cfg_hit <= cfg_rd &&
        (sel_mem || sel_pf || sel_low_up || sel_high_up);
      if (!cfg_rd)
        cfg_rdata <= 32'h0000_0000;
      else if (sel_mem)
        cfg_rdata <= {memory_window_end_field_reg, `MWD_MEM_FLAG,
          memory_window_start_field_reg, `MWD_MEM_FLAG}; // [R3]
      else if (sel_pf)
        cfg_rdata <= {prefetch_window_end_field_reg, `MWD_WIDE_FLAG,
          prefetch_window_start_field_reg, `MWD_WIDE_FLAG}; // [R9]
      else if (sel_low_up)
        cfg_rdata <= pf_low_up_reg;
      else if (sel_high_up)
        cfg_rdata <= pf_high_up_reg;
      else
        cfg_rdata <= 32'h0000_0000;
    end
  end

  // Forward decision, one cycle after the address is offered.
  // Upstream traffic crosses when inside a window; downstream traffic
  // crosses when outside all windows (positive decode upstream, inverse decode downstream).
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fwd_valid <= 1'b0;
      fwd_hit <= 1'b0;
      fwd_cross <= 1'b0;
    end
    else
    begin
      fwd_valid <= txn_valid;
      fwd_hit <= txn_valid && in_any; // [R4]
      fwd_cross <= txn_valid &&
        (txn_from_upstream ? in_any : !in_any); // [R10]
    end
  end

endmodule

// file: mwd_window_assertions.sv
// Port checker for the memory window decode block.
// Bound to mwd_window; sees only its ports, one clock domain.
`timescale 1ns/10ps
module mwd_window_chk (
  input wire clock, input wire reset_n,
  input wire cfg_wr, input wire cfg_rd, input wire [7:0] cfg_addr,
  input wire [3:0] cfg_be, input wire [31:0] cfg_wdata,
  input wire [31:0] cfg_rdata, input wire cfg_hit,
  input wire txn_valid, input wire [63:0] txn_addr,
  input wire txn_from_upstream,
  input wire fwd_valid, input wire fwd_hit, input wire fwd_cross
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire [5:0] dw = cfg_addr[7:2];
  chk_mem_nibble: assert property (cfg_rd && dw == 6'h08 |=>
    cfg_hit && cfg_rdata[3:0] == 4'h0 && cfg_rdata[19:16] == 4'h0)
    else $error("memory window low nibbles not zero");
  chk_wide_nibble: assert property (cfg_rd && dw == 6'h09 |=>
    cfg_hit && cfg_rdata[3:0] == 4'h1 && cfg_rdata[19:16] == 4'h1)
    else $error("prefetch window low nibbles not one");
  chk_base_write: assert property (cfg_wr && cfg_be[1:0] == 2'h3 &&
    dw == 6'h08 ##1 cfg_rd && !cfg_wr && dw == 6'h08 |=>
    cfg_rdata[15:4] == $past(cfg_wdata[15:4], 2))
    else $error("memory base field lost");
  chk_limit_write: assert property (cfg_wr && cfg_be[3:2] == 2'h3 &&
    dw == 6'h08 ##1 cfg_rd && !cfg_wr && dw == 6'h08 |=>
    cfg_rdata[31:20] == $past(cfg_wdata[31:20], 2))
    else $error("memory limit field lost");
  chk_upper_write: assert property (cfg_wr && cfg_be == 4'hf &&
    dw == 6'h0a ##1 cfg_rd && !cfg_wr && dw == 6'h0a |=>
    cfg_rdata == $past(cfg_wdata, 2))
    else $error("upper base register lost");
  chk_up_cross: assert property (txn_valid && txn_from_upstream |=>
    fwd_valid && fwd_cross == fwd_hit)
    else $error("upstream forward mismatch");
  chk_down_cross: assert property (txn_valid && !txn_from_upstream |=>
    fwd_valid && fwd_cross == !fwd_hit)
    else $error("downstream forward mismatch");
  chk_idle_decode: assert property (!txn_valid |=>
    !fwd_valid && !fwd_hit && !fwd_cross)
    else $error("decode active without address");
  cover property (fwd_hit && fwd_cross);
  cover property (fwd_cross && !fwd_hit);
  cover property (cfg_hit);
  cover property (cfg_wr ##1 cfg_rd);
endmodule
bind mwd_window mwd_window_chk u_chk (.*);

// file: mwd_far_side.sv
// Far side model: offers one memory address per call.
// Caller enters just after a rising edge; released lines invert.
`timescale 1ns/10ps
module mwd_far_side (
  // Clock in, address out
  input wire clock,
  output logic txn_valid = 1'h0,
  output logic [63:0] txn_addr = 64'h0,
  output logic txn_from_upstream = 1'h0
);
  task send(input logic [63:0] a, input logic up);
    txn_valid = 1'h1;
    txn_addr = a;
    txn_from_upstream = up;
    @(posedge clock);
    #1;
    txn_valid = 1'h0;
    // Stale address would hide a missing valid check
    txn_addr = ~a;
  endtask
endmodule

// file: mwd_window_tb_top.sv
// Testbench for mwd_window: config accesses and decode.
// Inputs change 1 ns after the rising edge.
`timescale 1ns/10ps
module mwd_window_tb_top;
  logic clock = 0, reset_n = 0, cfg_wr = 0, cfg_rd = 0;
  logic [7:0] cfg_addr = 8'h0;
  logic [3:0] cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata;
  logic cfg_hit, txn_valid, txn_from_upstream;
  logic fwd_valid, fwd_hit, fwd_cross;
  logic [63:0] txn_addr;
  int n_fail = 0, checks = 0;
  always #4 clock = ~clock;
  mwd_window u_dut (.*);
  mwd_far_side u_far (.*);
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tick;
    @(posedge clock);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    cfg_wr = 1'h1;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    tick;
    cfg_wr = 1'h0;
    tick;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    cfg_rd = 1'h1;
    cfg_addr = a;
    tick;
    cfg_rd = 1'h0;
    cmp(cfg_rdata, exp);
    cmp(cfg_hit, 1'h1);
    tick;
  endtask
  task rd_miss(input logic [7:0] a);
    cmp(cfg_hit, 1'h0);
    cfg_rd = 1'h1;
    cfg_addr = a;
    tick;
    cfg_rd = 1'h0;
    cmp(cfg_rdata, 32'h0);
    cmp(cfg_hit, 1'h0);
    tick;
  endtask
  task wr_rd(input logic [7:0] a, input logic [31:0] d, exp);
    cfg_wr = 1'h1;
    cfg_addr = a;
    cfg_be = 4'hf;
    cfg_wdata = d;
    tick;
    cfg_wr = 1'h0;
    rd(a, exp);
  endtask
  task txn(input logic [63:0] a, input logic up, h, c);
    u_far.send(a, up);
    cmp(fwd_valid, 1'h1);
    cmp(fwd_hit, h);
    cmp(fwd_cross, c);
    tick;
  endtask
  task report_and_stop;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clock);
    #1 reset_n = 1'h1;
    rd(8'h20, 32'h0);
    rd(8'h24, 32'h00010001);
    rd(8'h2c, 32'h0);
    txn(64'h000fffff, 1'h1, 1'h1, 1'h1);
    wr_rd(8'h20, 32'h00f0001f, 32'h00f00010);
    wr(8'h30, 4'hf, 32'hffffffff);
    rd_miss(8'h30);
    rd(8'h20, 32'h00f00010);
    wr(8'h24, 4'hf, 32'h7ff05000);
    wr_rd(8'h28, 32'h1, 32'h1);
    wr(8'h2c, 4'h1, 32'h1);
    rd(8'h24, 32'h7ff15001);
    rd(8'h2c, 32'h1);
    txn(64'h00100000, 1'h1, 1'h1, 1'h1);
    txn(64'h000fffff, 1'h1, 1'h0, 1'h0);
    txn(64'h00ffffff, 1'h1, 1'h1, 1'h1);
    txn(64'h01000000, 1'h1, 1'h0, 1'h0);
    txn(64'h100100000, 1'h1, 1'h0, 1'h0);
    txn(64'h150000000, 1'h1, 1'h1, 1'h1);
    txn(64'h17fffffff, 1'h1, 1'h1, 1'h1);
    txn(64'h050000000, 1'h1, 1'h0, 1'h0);
    txn(64'h180000000, 1'h1, 1'h0, 1'h0);
    txn(64'h00100000, 1'h0, 1'h1, 1'h0);
    txn(64'h02000000, 1'h0, 1'h0, 1'h1);
    wr(8'h20, 4'hf, 32'h00100020);
    txn(64'h00100000, 1'h1, 1'h0, 1'h0);
    txn(64'h00200000, 1'h0, 1'h0, 1'h1);
    reset_n = 1'h0;
    tick;
    reset_n = 1'h1;
    rd(8'h24, 32'h00010001);
    rd(8'h28, 32'h0);
    rd(8'h20, 32'h0);
    txn(64'h00080000, 1'h1, 1'h1, 1'h1);
    report_and_stop;
  end
endmodule
